// ### common/loop_switch_pkg.sv
// Constants and types shared by the loop switch and its envelope detector
package loop_switch_pkg;

	// Cell count and the cell of each role
	localparam int unsigned CELLS = 2;
	localparam int unsigned RETIME_SOURCE_CELL = 0;
	localparam int unsigned RETIME_TARGET_CELL = 1;

	// Clock rate, in picoseconds per period
	localparam int unsigned CLOCK_PERIOD_PS = 8000;
	// One serial bit per clock in this model
	localparam int unsigned BITS_PER_CLOCK = 1;

	// Longest time to bit phase lock, in bit times
	localparam int unsigned LOCK_BIT_TIMES = 2500;
	localparam int unsigned LOCK_CYCLES = LOCK_BIT_TIMES / BITS_PER_CLOCK;

	// Longest time to frequency lock after power-up, in microseconds
	localparam int unsigned FREQ_LOCK_US = 500;
	localparam int unsigned FREQ_LOCK_CYCLES = (FREQ_LOCK_US * 1000000) / CLOCK_PERIOD_PS;

	// Quiet cycles after the last transition before the carrier is declared gone
	localparam int unsigned ENVELOPE_WINDOW = 16;

	// Reset values
	localparam logic RESET_DATA = 1'h0;
	localparam logic RESET_PRESENT = 1'h0;

	// Which cells are inserted: bit 0 cell 0, bit 1 cell 1
	typedef enum logic [1:0] {
		CFG_NONE = 2'h0,
		CFG_ENTRY = 2'h1,
		CFG_EXIT = 2'h2,
		CFG_BOTH = 2'h3
	} config_type;

	// Retiming lock progress
	typedef enum logic [1:0] {
		LOCK_WAIT_FREQ = 2'h0,
		LOCK_ACQUIRE = 2'h1,
		LOCK_HELD = 2'h2
	} lock_state_type;

endpackage

// ### common/line_activity_if.sv
// Serial line and its carrier-present answer between switch and detector
`timescale 1ns/1ps
`default_nettype none
interface line_activity_if;
	logic lineData;
	logic present;
	// Switch side hands the line over and reads the answer
	modport owner (output lineData, input present);
	// Detector side watches the line
	modport monitor (input lineData, output present);
endinterface
`default_nettype wire

// ### design/envelope_detector.sv
// Carrier detector: high while transitions keep arriving on the line
`timescale 1ns/1ps
`default_nettype none
module envelope_detector #(
	parameter int unsigned WINDOW = loop_switch_pkg::ENVELOPE_WINDOW
) (
	input wire logic clock,
	input wire logic arst_n,
	line_activity_if.monitor line
);
	import loop_switch_pkg::*;

	localparam int unsigned COUNT_W = $clog2(WINDOW + 1);
	localparam logic [COUNT_W-1:0] QUIET_LIMIT = COUNT_W'(WINDOW);

	logic lastBit;
	logic [COUNT_W-1:0] quietCount;
	logic presentReg;

	// Transition seen and the next quiet count
	wire edgeSeen = line.lineData ^ lastBit;
	wire quietFull = (quietCount == QUIET_LIMIT);
	wire [COUNT_W-1:0] next_quietCount = edgeSeen ? '0 : (quietFull ? quietCount : quietCount + 1'b1);

	// Envelope tracking; starts with no carrier
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lastBit <= RESET_DATA;
			quietCount <= QUIET_LIMIT;
			presentReg <= RESET_PRESENT;
		end else begin
			lastBit <= line.lineData;
			quietCount <= next_quietCount;
			presentReg <= (next_quietCount != QUIET_LIMIT);
		end
	end

	assign line.present = presentReg;
endmodule
`default_nettype wire

// ### design/loop_switch.sv
// Two-cell loop bypass switch with retiming on one path
//
// Notes on behaviour
// - A cell whose insert pin is high sends loop data to its drive and passes the drive's data on round the loop.
// - A cell whose insert pin is low skips its drive so the loop no longer uses that drive's returned data.
// - With cell 0 on the cable, loop out is loop in when cell 1 skips, else drive 1's data, and drive 1 gets loop in.
// - With cell 1 on the cable, loop out is loop in when cell 0 skips, else drive 0's data, and drive 0 gets loop in.
// - With cell 0 inserted and a drive on cell 1, data is retimed before it enters that drive.
// - The cell without a drive is the cable port, so the two cells always take opposite roles.
// - Each carrier-present output is high while activity is seen on its cable input and low otherwise.
// - Carrier-present reports the incoming cable in both the entry and the exit arrangement.
// - An insert pin left undriven reads high, so the cell inserts its drive by default.
// - Once frequency lock is reached, retiming reaches bit phase lock within 2500 bit times of valid incoming data.
`timescale 1ns/1ps
`default_nettype none
module loop_switch #(
	parameter int unsigned LOCK_CYCLES = loop_switch_pkg::LOCK_CYCLES,
	parameter int unsigned FREQ_LOCK_CYCLES = loop_switch_pkg::FREQ_LOCK_CYCLES,
	parameter int unsigned ENVELOPE_WINDOW = loop_switch_pkg::ENVELOPE_WINDOW
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [loop_switch_pkg::CELLS-1:0] fromDrive,
	input wire logic [loop_switch_pkg::CELLS-1:0] skipPinLevel_n,
	input wire logic [loop_switch_pkg::CELLS-1:0] skipPinDriven,
	output logic [loop_switch_pkg::CELLS-1:0] toDrive,
	output logic [loop_switch_pkg::CELLS-1:0] carrierPresent,
	output logic [loop_switch_pkg::CELLS-1:0] cellInserted,
	output loop_switch_pkg::config_type switchConfig,
	output logic frequencyLocked,
	output logic phaseLocked
);
	import loop_switch_pkg::*;

	localparam int unsigned LOCK_W = $clog2(LOCK_CYCLES + 1);
	localparam int unsigned FREQ_W = $clog2(FREQ_LOCK_CYCLES + 1);
	localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
	localparam logic [FREQ_W-1:0] FREQ_LAST = FREQ_W'(FREQ_LOCK_CYCLES - 1);

	// Effective insert level of one pin: an undriven pin is pulled high
	function automatic logic pin_inserts(input logic level_n, input logic driven);
		pin_inserts = level_n | ~driven;
	endfunction

	// Configuration code from the insert pins: bit 0 is cell 0's insert level, bit 1 is cell 1's
	function automatic config_type pins_to_config(input logic ins0, input logic ins1);
		pins_to_config = config_type'({ins1, ins0});
	endfunction

	// Insert decode, combinational so the paths follow the pins at once
	wire insert0 = pin_inserts(skipPinLevel_n[0], skipPinDriven[0]);
	wire insert1 = pin_inserts(skipPinLevel_n[1], skipPinDriven[1]);
	wire config_type pinConfig = pins_to_config(insert0, insert1);

	// Cell 0 mux feeds the retimer; it takes the drive-0 data when cell 0 inserts
	wire retimeSource = insert0 ? fromDrive[0] : fromDrive[1];
	// Cell 1 mux is unregistered: drive-1 data when cell 1 inserts, else the other input
	wire directPath = insert1 ? fromDrive[1] : fromDrive[0];

	// Retiming stage toward cell 1, clocked by the reference-derived clock
	logic retimedBit;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			retimedBit <= RESET_DATA;
		end else begin
			retimedBit <= retimeSource;
		end
	end

	// Cell 1 output is the retimed path, cell 0 output is the direct path
	assign toDrive = {retimedBit, directPath};

	// One envelope detector per incoming direction
	logic [CELLS-1:0] presentRaw;
	genvar g;
	generate
		for (g = 0; g < CELLS; g++) begin : gen_detect
			line_activity_if probe ();
			assign probe.lineData = fromDrive[g];
			assign presentRaw[g] = probe.present;
			envelope_detector #(
				.WINDOW(ENVELOPE_WINDOW)
			) detector (
				.clock(clock),
				.arst_n(arst_n),
				.line(probe)
			);
		end
	endgenerate

	// Carrier on the input that now feeds the retimer
	wire sourceCarrier = insert0 ? presentRaw[0] : presentRaw[1];

	// Source change restarts phase acquisition
	logic lastInsert0;
	wire sourceChanged = insert0 ^ lastInsert0;
	wire dataValid = sourceCarrier & ~sourceChanged;

	// Frequency lock count after power-up
	logic [FREQ_W-1:0] freqCount;
	logic freqDone;
	wire freqReached = (freqCount == FREQ_LAST);
	wire [FREQ_W-1:0] next_freqCount = freqDone ? freqCount : freqCount + 1'b1;
	wire next_freqDone = freqDone | freqReached;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			freqCount <= '0;
			freqDone <= 1'h0;
			lastInsert0 <= 1'h1;
		end else begin
			freqCount <= next_freqCount;
			freqDone <= next_freqDone;
			lastInsert0 <= insert0;
		end
	end

	// Phase acquisition state and bit count
	lock_state_type lockState;
	lock_state_type next_lockState;
	logic [LOCK_W-1:0] lockCount;
	logic [LOCK_W-1:0] next_lockCount;
	wire lockReached = (lockCount == LOCK_LAST);

	// Lock progress: wait for frequency, count valid bits, hold while data stays
	always_comb begin
		next_lockState = lockState;
		next_lockCount = '0;
		unique case (lockState)
			LOCK_WAIT_FREQ: begin
				if (freqDone) begin
					next_lockState = LOCK_ACQUIRE;
				end
			end
			LOCK_ACQUIRE: begin
				if (!dataValid) begin
					next_lockCount = '0;
				end else if (lockReached) begin
					next_lockState = LOCK_HELD;
				end else begin
					next_lockCount = lockCount + 1'b1;
				end
			end
			LOCK_HELD: begin
				if (!dataValid) begin
					next_lockState = LOCK_ACQUIRE;
				end
			end
			default: begin
				next_lockState = LOCK_WAIT_FREQ;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lockState <= LOCK_WAIT_FREQ;
			lockCount <= '0;
		end else begin
			lockState <= next_lockState;
			lockCount <= next_lockCount;
		end
	end

	// Registered status outputs
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			carrierPresent <= '0;
			cellInserted <= '0;
			switchConfig <= CFG_NONE;
			frequencyLocked <= 1'h0;
			phaseLocked <= 1'h0;
		end else begin
			carrierPresent <= presentRaw;
			cellInserted <= {insert1, insert0};
			switchConfig <= pinConfig;
			frequencyLocked <= next_freqDone;
			phaseLocked <= (next_lockState == LOCK_HELD);
		end
	end
endmodule
`default_nettype wire

// ### sim/drive_model.sv
// Behavioural drive transceiver hung on one cell
`timescale 1ns/1ps
`default_nettype none
module drive_model (
	input wire logic clock,
	input wire logic rxBit,
	output logic txBit = 1'h0
);
	// Sends back what it heard one bit later, changing just after the rising edge
	always @(posedge clock) begin
		txBit <= rxBit;
	end
endmodule
`default_nettype wire

// ### sim/loop_switch_properties.sv
// Concurrent checks on the loop switch ports
`timescale 1ns/1ps
`default_nettype none
module loop_switch_properties (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [1:0] fromDrive,
	input wire logic [1:0] skipPinLevel_n,
	input wire logic [1:0] skipPinDriven,
	input wire logic [1:0] toDrive,
	input wire logic [1:0] carrierPresent,
	input wire logic [1:0] cellInserted,
	input wire loop_switch_pkg::config_type switchConfig,
	input wire logic frequencyLocked,
	input wire logic phaseLocked
);
	import loop_switch_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Pin level after the pull-up
	wire [1:0] ins = skipPinLevel_n | ~skipPinDriven;
	// A fresh transition on one drive input
	sequence s_edge(int n);
		$past(arst_n) && fromDrive[n] != $past(fromDrive[n]);
	endsequence
	a_loop_insert: assert property (ins[1] |-> toDrive[0] == fromDrive[1]) else $error("loop out wrong");
	a_loop_skip: assert property (!ins[1] |-> toDrive[0] == fromDrive[0]) else $error("skip wrong");
	a_retime_entry: assert property (ins[0] |=> toDrive[1] == $past(fromDrive[0])) else $error("retime wrong");
	a_retime_exit: assert property (!ins[0] |=> toDrive[1] == $past(fromDrive[1])) else $error("exit wrong");
	a_insert_track: assert property (1'b1 |=> cellInserted == $past(ins)) else $error("insert wrong");
	a_config_roles: assert property (switchConfig == cellInserted) else $error("config wrong");
	a_carrier_cell0: assert property (s_edge(0) |-> ##2 carrierPresent[0]) else $error("carrier 0 late");
	a_carrier_cell1: assert property (s_edge(1) |-> ##2 carrierPresent[1]) else $error("carrier 1 late");
	a_lock_order: assert property (phaseLocked |-> frequencyLocked) else $error("lock order");
	a_lock_drop: assert property ($changed(ins[0]) |=> !phaseLocked) else $error("lock kept");
endmodule
`default_nettype wire

// ### sim/test_loop_switch.sv
// Self-checking bench for the loop switch
`timescale 1ns/1ps
`default_nettype none
module test_loop_switch;
	import loop_switch_pkg::*;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic [1:0] level_n = 2'h3;
	logic [1:0] driven = 2'h0;
	logic loopBit = 1'h0;
	logic driveCell = 1'h1;
	int errors = 0;
	int samples_checked = 0;
	wire txBit;
	wire [1:0] toDrive;
	wire [1:0] carrierPresent;
	wire [1:0] cellInserted;
	wire config_type switchConfig;
	wire frequencyLocked;
	wire phaseLocked;
	// Cable bit and drive bit on their cells; released pins read high
	wire [1:0] fromDrive = driveCell ? {txBit, loopBit} : {loopBit, txBit};
	wire [1:0] ins = level_n | ~driven;
	// Reference clock for the retimer
	always #4 clock = ~clock;
	loop_switch #(.LOCK_CYCLES(10), .FREQ_LOCK_CYCLES(8), .ENVELOPE_WINDOW(4)) i_dut (
		.clock(clock),
		.arst_n(arst_n),
		.fromDrive(fromDrive),
		.skipPinLevel_n(level_n),
		.skipPinDriven(driven),
		.toDrive(toDrive),
		.carrierPresent(carrierPresent),
		.cellInserted(cellInserted),
		.switchConfig(switchConfig),
		.frequencyLocked(frequencyLocked),
		.phaseLocked(phaseLocked)
	);
	drive_model i_drive (.clock(clock), .rxBit(toDrive[driveCell]), .txBit(txBit));
	task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One cable bit: direct path at once, retimed path after the next rising edge
	task automatic step(input logic b);
		logic src;
		@(negedge clock);
		loopBit = b;
		#1;
		src = ins[0] ? fromDrive[0] : fromDrive[1];
		check("direct", {1'h0, (ins[1] ? fromDrive[1] : fromDrive[0])}, {1'h0, toDrive[0]});
		@(posedge clock);
		#1;
		check("retimed", {1'h0, src}, {1'h0, toDrive[1]});
	endtask
	task automatic run(input int n, input logic [7:0] pat);
		for (int i = 0; i < n; i++) begin
			step(pat[i % 8]);
		end
	endtask
	// Cable on cell 0, drive on cell 1 skipped then inserted
	task automatic t_entry();
		@(negedge clock);
		level_n = 2'h0;
		driven = 2'h2;
		run(12, 8'hB4);
		check("inserted", 2'h1, cellInserted);
		check("config", CFG_ENTRY, switchConfig);
		check("carrier", 2'h3, carrierPresent);
		@(negedge clock);
		driven = 2'h0;
		run(12, 8'hB4);
		check("config", CFG_BOTH, switchConfig);
	endtask
	// Drive moved to cell 0, cable on cell 1
	task automatic t_exit();
		@(negedge clock);
		driveCell = 1'h0;
		driven = 2'h1;
		run(12, 8'hB4);
		check("config", CFG_EXIT, switchConfig);
		check("carrier", 2'h3, carrierPresent);
		@(negedge clock);
		driven = 2'h0;
		run(12, 8'h3C);
	endtask
	// Quiet cable, then lock on fresh traffic, then unlock
	task automatic t_lock();
		run(12, 8'h00);
		check("quiet", 2'h0, carrierPresent);
		for (int i = 0; i < 40 && phaseLocked !== 1'h1; i++) begin
			step(i[1]);
		end
		check("locked", 2'h3, {phaseLocked, frequencyLocked});
		if (phaseLocked !== 1'h1) begin
			complete_run();
		end
		@(negedge clock);
		driven = 2'h1;
		run(3, 8'h0F);
		check("unlocked", 2'h0, {1'h0, phaseLocked});
	endtask
	task automatic complete_run();
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clock);
		arst_n = 1'h1;
		t_entry();
		t_exit();
		t_lock();
		complete_run();
	end
endmodule
bind loop_switch loop_switch_properties i_props (.clock(clock), .arst_n(arst_n), .fromDrive(fromDrive),
	.skipPinLevel_n(skipPinLevel_n), .skipPinDriven(skipPinDriven), .toDrive(toDrive),
	.carrierPresent(carrierPresent), .cellInserted(cellInserted), .switchConfig(switchConfig),
	.frequencyLocked(frequencyLocked), .phaseLocked(phaseLocked));
`default_nettype wire
